// ==== design/dcw_pkg.sv ====
// ---------------------------------------------------------------------
// Shared constants for the drive control word decoder.
// ---------------------------------------------------------------------
package dcw_pkg;

  // -------------------------------------------------------------------
  // Register byte addresses on the APB.
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_CW1 = 8'h00;  // control_word_one.
  localparam logic [7:0] ADDR_TSEL = 8'h04; // Telegram selections.
  localparam logic [7:0] ADDR_CFG = 8'h08;  // Layout and lengths.
  localparam logic [7:0] ADDR_STAT = 8'h0c; // Decoder state.

  // -------------------------------------------------------------------
  // Telegram numbers and reset selections.
  // -------------------------------------------------------------------
  localparam logic [9:0] TGM_FREE = 10'h3e7; // Free interconnection.
  localparam logic [9:0] TGM_PROC = 10'h014; // Process-industry type.
  localparam logic [9:0] TGM_RST = 10'h001;  // Selection after reset.
  localparam logic [3:0] LEN_MAX = 4'h8;     // Longest free telegram.
  localparam logic [3:0] LEN_RST = 4'h2;     // Free length at reset.

  // -------------------------------------------------------------------
  // Field positions.
  // -------------------------------------------------------------------
  localparam int SEC_LSB = 16;  // telegram_select_secondary in TSEL.
  localparam int EXT_LSB = 4;   // Appended words in CFG.
  localparam int LEN_LSB = 8;   // Free telegram length in CFG.
  localparam int B_ON = 0;      // Switch-on.
  localparam int B_COAST = 1;   // coast_stop_cmd, active low.
  localparam int B_HALT = 2;    // fast_halt_cmd, active low.
  localparam int B_ENOP = 3;    // Enable operation.
  localparam int B_RFG = 4;     // Ramp generator not forced to zero.
  localparam int B_RUN = 5;     // Ramp generator not frozen.
  localparam int B_SETP = 6;    // Setpoint enable.
  localparam int B_ACK = 7;     // Fault acknowledge.
  localparam int B_MST = 10;    // Master control valid.
  localparam int B_REV = 11;    // Direction reversal.
  localparam int B_UP = 13;     // motorized_pot up.
  localparam int B_DN = 14;     // motorized_pot down.
  localparam int B_CDS = 15;    // command_data_set bit 0.

  // -------------------------------------------------------------------
  // Ramp selection codes and sequencing states.
  // -------------------------------------------------------------------
  localparam logic [1:0] RAMP_ACCEL = 2'b00; // accel_ramp_time.
  localparam logic [1:0] RAMP_DECEL = 2'b01; // decel_ramp_time.
  localparam logic [1:0] RAMP_HALT = 2'b10;  // fast_halt_ramp_time.

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READY = 3'b001,
    ST_RUN = 3'b010,
    ST_FAULT = 3'b011,
    ST_LOCKOUT = 3'b100
  } dcw_state_type;

  // Telegram in force for a pair of selections.
  function automatic logic [9:0] dcw_active(input logic [9:0] prim,
                                            input logic [9:0] sec);
    if (prim < TGM_FREE) return prim;
    if (sec < TGM_FREE) return sec;
    return TGM_FREE;
  endfunction

endpackage

// ==== design/dcw_edge.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------
// Holds the last valid control word and flags its rising bits.
// ---------------------------------------------------------------------
module dcw_edge (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Received word.
  input wire logic strobe,
  input wire logic [15:0] word,
  // Decoded result.
  output logic [15:0] word_q,
  output logic [15:0] rise_q,
  output logic new_q
);

  logic [15:0] word_next;
  logic [15:0] rise_next;
  logic new_next;

  // Words without master control never reach the compare, so an
  // edge is measured between two valid words, or against zero after reset.
  always_comb begin
    word_next = word_q;
    rise_next = 16'h0000;
    new_next = 1'b0;
    if (strobe && word[dcw_pkg::B_MST]) begin // R13 R21
      word_next = word;
      rise_next = word & ~word_q; // R21
      new_next = 1'b1;
    end
  end

  // Register stage only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 16'h0000;
      rise_q <= 16'h0000;
      new_q <= 1'b0;
    end else begin
      word_q <= word_next;
      rise_q <= rise_next;
      new_q <= new_next;
    end
  end

endmodule // dcw_edge
`default_nettype wire

// ==== design/dcw_decoder.sv ====
// Summary of operation
// R01: Primary 999 takes secondary telegram selection.
// R02: Secondary mode locks content, allows appended words.
// R03: Both 999: master sets length, free content.
// R04: Layout select picks native or process layout.
// R05: Bit 0 rise: ready, runs if bit 3.
// R06: Bit 1 low coasts motor at once.
// R07: Bit 2 low brakes with fast halt ramp.
// R08: Bit 3 low cancels pulses; high permits.
// R09: Bit 4 low forces ramp output zero.
// R10: Bit 5 low freezes ramp output.
// R11: Bit 6 picks accel or decel ramp.
// R12: Bit 7 rise acknowledges; ON held gives lockout.
// R13: Bit 10 marks process data valid.
// R14: Bit 11 inverts setpoint, not telegram 20.
// R15: Bit 13 raises motorized pot setpoint.
// R16: Bit 14 lowers motorized pot setpoint.
// R17: Bit 15 selects command data set.
// R18: Entering telegram 20 keeps specific bit functions.
// R19: Bits 8, 9, 12 do nothing.
// R20: Primary below 999 copies, locks everything.
// R21: Edges compare consecutive valid words only.
`timescale 1ns/10ps
`default_nettype none
module dcw_decoder (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive fault from the protection logic.
  input wire logic drive_fault,
  // Sequencing commands.
  output logic pulse_enable,
  output logic coast_stop_cmd,
  output logic fast_halt_cmd,
  output logic [1:0] ramp_select,
  output logic ramp_zero,
  output logic ramp_hold,
  output logic setpoint_enable,
  output logic fault_ack,
  // Setpoint modifiers.
  output logic dir_reverse,
  output logic pot_up,
  output logic pot_down,
  output logic command_data_set,
  output logic data_valid
);

  // -------------------------------------------------------------------
  // APB and configuration state.
  // -------------------------------------------------------------------
  logic pready_reg, pready_next;          // Answer flag.
  logic pslverr_reg, pslverr_next;        // Error flag.
  logic [31:0] prdata_reg, prdata_next;   // Read data.
  logic [9:0] prim_reg, prim_next;        // telegram_select_primary.
  logic [9:0] sec_reg, sec_next;          // telegram_select_secondary.
  logic [3:0] ext_reg, ext_next;          // Appended words.
  logic [3:0] len_reg, len_next;          // Free telegram length.
  logic layout_reg, layout_next;          // word_layout_select.
  logic keep_reg, keep_next;              // Keep specific bits.
  logic [15:0] raw_reg, raw_next;         // Last word, valid or not.
  logic acc;                              // First access cycle.
  logic wr;                               // Write takes effect.
  logic wr_cw;                            // New control word.
  logic cfg_err;                          // Locked field change.
  logic [9:0] tgm_now, tgm_nx;            // Active telegram.
  logic mode_sec, mode_free;              // Selection modes.
  logic proc_lay;                         // Process layout in use.
  logic spec_en;                          // Bits 11, 13, 14 live.

  // -------------------------------------------------------------------
  // Decoder state.
  // -------------------------------------------------------------------
  dcw_pkg::dcw_state_type st_reg, st_next;
  logic [15:0] w;                         // Last valid word.
  logic [15:0] rise;                      // Rising bits of it.
  logic new_w;                            // Fresh valid word.
  logic run_ok;                           // Run conditions met.
  logic pulse_reg, pulse_next;
  logic coast_reg, coast_next;
  logic halt_reg, halt_next;
  logic [1:0] ramp_reg, ramp_next;
  logic rzero_reg, rzero_next;
  logic rhold_reg, rhold_next;
  logic setp_reg, setp_next;
  logic ack_reg, ack_next;
  logic rev_reg, rev_next;
  logic up_reg, up_next;
  logic dn_reg, dn_next;
  logic cds_reg, cds_next;
  logic valid_reg, valid_next;

  // -------------------------------------------------------------------
  // Telegram mode decode.
  // -------------------------------------------------------------------
  assign tgm_now = dcw_pkg::dcw_active(prim_reg, sec_reg); // R01
  assign mode_sec = (prim_reg == dcw_pkg::TGM_FREE) &&
                    (sec_reg < dcw_pkg::TGM_FREE); // R01
  assign mode_free = (tgm_now == dcw_pkg::TGM_FREE); // R03
  // The process layout hides bits 11, 13 and 14 unless they were inherited, and bit 15 always.
  assign proc_lay = mode_free ? layout_reg :
                    (tgm_now == dcw_pkg::TGM_PROC); // R04
  assign spec_en = !proc_lay || keep_reg; // R18

  // A wait state is inserted so every answer leaves a flip-flop.
  assign acc = psel && penable && !pready_reg;
  assign wr = psel && penable && pready_reg && pwrite;
  assign wr_cw = wr && (paddr == dcw_pkg::ADDR_CW1);

  // A locked field may be rewritten with its own value only.
  assign cfg_err =
    ((pwdata[dcw_pkg::EXT_LSB +: 4] != ext_reg) && !mode_sec) || // R02 R20
    ((pwdata[dcw_pkg::LEN_LSB +: 4] != len_reg) && !mode_free) || // R03
    (pwdata[dcw_pkg::LEN_LSB +: 4] > dcw_pkg::LEN_MAX);

  // -------------------------------------------------------------------
  // Bus answer and configuration, next values.
  // -------------------------------------------------------------------
  always_comb begin
    pready_next = acc;
    pslverr_next = 1'b0;
    prdata_next = 32'h0000_0000;
    prim_next = prim_reg;
    sec_next = sec_reg;
    ext_next = ext_reg;
    len_next = len_reg;
    layout_next = layout_reg;
    raw_next = raw_reg;
    // Read data and error are prepared in the first access cycle.
    if (acc) begin
      case (paddr)
        dcw_pkg::ADDR_CW1: begin
          prdata_next = {16'h0000, w};
        end
        dcw_pkg::ADDR_TSEL: begin
          prdata_next = {6'h00, sec_reg, 6'h00, prim_reg};
        end
        dcw_pkg::ADDR_CFG: begin
          prdata_next = {20'h00000, len_reg, ext_reg, 3'h0, layout_reg};
          pslverr_next = pwrite && cfg_err;
        end
        dcw_pkg::ADDR_STAT: begin
          // State in 2:0, telegram in 12:3, flags in 15:13.
          prdata_next = {16'h0000, raw_reg[dcw_pkg::B_MST], keep_reg,
                         proc_lay, tgm_now, st_reg};
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
    end
    // Writes land at the edge where pready is seen high.
    if (wr_cw) begin
      raw_next = pwdata[15:0];
    end
    if (wr && (paddr == dcw_pkg::ADDR_TSEL)) begin
      prim_next = pwdata[9:0];
      if (pwdata[9:0] < dcw_pkg::TGM_FREE) begin
        sec_next = pwdata[9:0]; // R20
      end else begin
        sec_next = pwdata[dcw_pkg::SEC_LSB +: 10]; // R01
      end
    end
    // A rejected write changes nothing at all.
    if (wr && (paddr == dcw_pkg::ADDR_CFG) && !cfg_err) begin
      layout_next = pwdata[0]; // R04
      ext_next = pwdata[dcw_pkg::EXT_LSB +: 4]; // R02
      len_next = pwdata[dcw_pkg::LEN_LSB +: 4]; // R03
    end
  end

  // Inherited bit functions on a change into the process telegram.
  always_comb begin
    tgm_nx = dcw_pkg::dcw_active(prim_next, sec_next);
    keep_next = keep_reg;
    if (tgm_nx != dcw_pkg::TGM_PROC) begin
      keep_next = 1'b0;
    end else if (tgm_now != dcw_pkg::TGM_PROC) begin
      keep_next = 1'b1; // R18
    end
  end

  // Bus and configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      prim_reg <= dcw_pkg::TGM_RST;
      sec_reg <= dcw_pkg::TGM_RST;
      ext_reg <= 4'h0;
      len_reg <= dcw_pkg::LEN_RST;
      layout_reg <= 1'b0;
      keep_reg <= 1'b0;
      raw_reg <= 16'h0000;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      prim_reg <= prim_next;
      sec_reg <= sec_next;
      ext_reg <= ext_next;
      len_reg <= len_next;
      layout_reg <= layout_next;
      keep_reg <= keep_next;
      raw_reg <= raw_next;
    end
  end

  // -------------------------------------------------------------------
  // Valid word latch and edge detection.
  // -------------------------------------------------------------------
  dcw_edge u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .strobe(wr_cw),
    .word(pwdata[15:0]),
    .word_q(w),
    .rise_q(rise),
    .new_q(new_w)
  );

  // -------------------------------------------------------------------
  // Sequencing and command outputs, next values.
  // -------------------------------------------------------------------
  assign run_ok = w[dcw_pkg::B_ENOP] && w[dcw_pkg::B_COAST] &&
                  w[dcw_pkg::B_HALT];

  // A drive fault outranks every word; bits 8, 9 and 12 are never read.
  always_comb begin // R19
    st_next = st_reg;
    ack_next = new_w && rise[dcw_pkg::B_ACK]; // R12
    if (drive_fault) begin
      st_next = dcw_pkg::ST_FAULT;
    end else if (new_w) begin
      case (st_reg)
        dcw_pkg::ST_IDLE, dcw_pkg::ST_LOCKOUT: begin
          if (rise[dcw_pkg::B_ON]) begin // R05
            st_next = run_ok ? dcw_pkg::ST_RUN : dcw_pkg::ST_READY;
          end else if (!w[dcw_pkg::B_ON]) begin
            st_next = dcw_pkg::ST_IDLE;
          end
        end
        dcw_pkg::ST_READY: begin
          if (!w[dcw_pkg::B_ON] || !w[dcw_pkg::B_COAST] ||
              !w[dcw_pkg::B_HALT]) begin // R06 R07
            st_next = dcw_pkg::ST_IDLE;
          end else if (w[dcw_pkg::B_ENOP]) begin
            st_next = dcw_pkg::ST_RUN; // R08
          end
        end
        dcw_pkg::ST_RUN: begin
          if (!w[dcw_pkg::B_ON] || !w[dcw_pkg::B_COAST] ||
              !w[dcw_pkg::B_HALT]) begin // R06 R07
            st_next = dcw_pkg::ST_IDLE;
          end else if (!w[dcw_pkg::B_ENOP]) begin
            st_next = dcw_pkg::ST_READY; // R08
          end
        end
        dcw_pkg::ST_FAULT: begin
          if (rise[dcw_pkg::B_ACK]) begin // R12
            st_next = w[dcw_pkg::B_ON] ? dcw_pkg::ST_LOCKOUT :
                                         dcw_pkg::ST_IDLE;
          end
        end
        default: begin
          st_next = dcw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Levels other than data_valid follow the last valid word; invalid words leave them alone.
  always_comb begin
    // Pulses stop one edge after the word that takes them away is latched.
    pulse_next = (st_next == dcw_pkg::ST_RUN) && run_ok; // R08
    coast_next = !w[dcw_pkg::B_COAST]; // R06
    halt_next = !w[dcw_pkg::B_HALT]; // R07
    rzero_next = !w[dcw_pkg::B_RFG]; // R09
    rhold_next = !w[dcw_pkg::B_RUN]; // R10
    setp_next = w[dcw_pkg::B_SETP]; // R11
    if (!w[dcw_pkg::B_HALT]) begin
      ramp_next = dcw_pkg::RAMP_HALT; // R07
    end else if (w[dcw_pkg::B_SETP]) begin
      ramp_next = dcw_pkg::RAMP_ACCEL; // R11
    end else begin
      ramp_next = dcw_pkg::RAMP_DECEL; // R11
    end
    rev_next = spec_en && w[dcw_pkg::B_REV]; // R14
    up_next = spec_en && w[dcw_pkg::B_UP]; // R15
    dn_next = spec_en && w[dcw_pkg::B_DN]; // R16
    cds_next = !proc_lay && w[dcw_pkg::B_CDS]; // R17
    valid_next = raw_reg[dcw_pkg::B_MST]; // R13
  end

  // Sequencing and output registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= dcw_pkg::ST_IDLE;
      pulse_reg <= 1'b0;
      coast_reg <= 1'b0;
      halt_reg <= 1'b0;
      ramp_reg <= dcw_pkg::RAMP_ACCEL;
      rzero_reg <= 1'b0;
      rhold_reg <= 1'b0;
      setp_reg <= 1'b0;
      ack_reg <= 1'b0;
      rev_reg <= 1'b0;
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      cds_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      pulse_reg <= pulse_next;
      coast_reg <= coast_next;
      halt_reg <= halt_next;
      ramp_reg <= ramp_next;
      rzero_reg <= rzero_next;
      rhold_reg <= rhold_next;
      setp_reg <= setp_next;
      ack_reg <= ack_next;
      rev_reg <= rev_next;
      up_reg <= up_next;
      dn_reg <= dn_next;
      cds_reg <= cds_next;
      valid_reg <= valid_next;
    end
  end

  // -------------------------------------------------------------------
  // Output drive.
  // -------------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pulse_enable = pulse_reg;
  assign coast_stop_cmd = coast_reg;
  assign fast_halt_cmd = halt_reg;
  assign ramp_select = ramp_reg;
  assign ramp_zero = rzero_reg;
  assign ramp_hold = rhold_reg;
  assign setpoint_enable = setp_reg;
  assign fault_ack = ack_reg;
  assign dir_reverse = rev_reg;
  assign pot_up = up_reg;
  assign pot_down = dn_reg;
  assign command_data_set = cds_reg;
  assign data_valid = valid_reg;

  // -------------------------------------------------------------------
  // Checks.
  // -------------------------------------------------------------------
  property p_copy;
    @(posedge pclk) disable iff (!presetn)
    (prim_reg < dcw_pkg::TGM_FREE) |-> (sec_reg == prim_reg);
  endproperty
  a_copy: assert property (p_copy) else $error("secondary not copied"); // R20

  property p_len_lock;
    @(posedge pclk) disable iff (!presetn)
    !mode_free |=> $stable(len_reg);
  endproperty
  a_len_lock: assert property (p_len_lock) else $error("length moved"); // R03

  property p_ignore;
    @(posedge pclk) disable iff (!presetn)
    (wr_cw && !pwdata[dcw_pkg::B_MST]) |=> $stable(w) ##1 !new_w;
  endproperty
  a_ignore: assert property (p_ignore) else $error("invalid word used"); // R13

  property p_enop;
    @(posedge pclk) disable iff (!presetn)
    (new_w && !w[dcw_pkg::B_ENOP]) |=> !pulse_enable;
  endproperty
  a_enop: assert property (p_enop) else $error("pulses not cut"); // R08

  property p_coast;
    @(posedge pclk) disable iff (!presetn)
    (new_w && !w[dcw_pkg::B_COAST]) |=> coast_stop_cmd && !pulse_enable;
  endproperty
  a_coast: assert property (p_coast) else $error("coast missing"); // R06

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    (new_w && !w[dcw_pkg::B_HALT]) |=> ramp_select == dcw_pkg::RAMP_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("halt ramp missing"); // R07

  property p_on;
    @(posedge pclk) disable iff (!presetn)
    (new_w && rise[dcw_pkg::B_ON] && run_ok && !drive_fault &&
     st_reg == dcw_pkg::ST_IDLE) |=> ##1 pulse_enable;
  endproperty
  a_on: assert property (p_on) else $error("switch-on failed"); // R05

  property p_ack;
    @(posedge pclk) disable iff (!presetn)
    (new_w && rise[dcw_pkg::B_ACK] && w[dcw_pkg::B_ON] && !drive_fault &&
     st_reg == dcw_pkg::ST_FAULT) |=> st_reg == dcw_pkg::ST_LOCKOUT &&
     fault_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not to lockout"); // R12

  property p_rev;
    @(posedge pclk) disable iff (!presetn)
    (!spec_en && $stable(spec_en)) |=> !dir_reverse && !pot_up;
  endproperty
  a_rev: assert property (p_rev) else $error("specific bit leaked"); // R14

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("answer late"); // APB wait state, no rule.

endmodule // dcw_decoder
`default_nettype wire

// ==== tb/dcw_plc.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------
// Fieldbus master model: reaches the decoder over APB.
// ---------------------------------------------------------------------
module dcw_plc (
  // Clock.
  input wire logic pclk,
  // APB master side.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hff;
    pwdata = 32'h0;
  end

  // One transfer; the request stands until pready is seen high or 64 edges pass.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    q = prdata;
    err = pslverr;
    // Released lines carry the inverse so stale values are never trusted.
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  // Sends one control word; the master-control bit says if it is live.
  task automatic send_word(input logic [15:0] w, input logic live);
    logic [31:0] q;
    logic e;
    w[10] = live;
    xfer(1'b1, dcw_pkg::ADDR_CW1, {16'h0, w}, q, e);
  endtask
endmodule // dcw_plc
`default_nettype wire

// ==== tb/drive_control_word_decoder_test.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------
// Self-checking bench for the control word decoder.
// ---------------------------------------------------------------------
module drive_control_word_decoder_test;
  logic pclk = 1'b0, presetn = 1'b0, drive_fault = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e, pulse_enable, coast_stop_cmd, fast_halt_cmd, ramp_zero;
  logic ramp_hold, setpoint_enable, fault_ack, dir_reverse, pot_up;
  logic pot_down, command_data_set, data_valid;
  logic [1:0] ramp_select;
  logic [10:0] lv;
  int n_fail = 0, comparisons = 0, n_ack = 0;
  logic [15:0] tw [7] = '{16'h047b, 16'h046f, 16'h045f, 16'h043f,
                          16'h047d, 16'hec7f, 16'h177f};
  logic [10:0] tl [7] = '{11'h310, 11'h050, 11'h030, 11'h080,
                          11'h410, 11'h01f, 11'h010};

  dcw_decoder u_dcw_decoder (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_fault(drive_fault), .pulse_enable(pulse_enable),
    .coast_stop_cmd(coast_stop_cmd), .fast_halt_cmd(fast_halt_cmd),
    .ramp_select(ramp_select), .ramp_zero(ramp_zero),
    .ramp_hold(ramp_hold), .setpoint_enable(setpoint_enable),
    .fault_ack(fault_ack), .dir_reverse(dir_reverse), .pot_up(pot_up),
    .pot_down(pot_down), .command_data_set(command_data_set),
    .data_valid(data_valid));
  dcw_plc u_dcw_plc (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Level outputs packed so one compare covers a whole word.
  assign lv = {coast_stop_cmd, fast_halt_cmd, ramp_select, ramp_zero,
               ramp_hold, setpoint_enable, dir_reverse, pot_up, pot_down,
               command_data_set};
  always #5 pclk = ~pclk;
  // Counts acknowledge pulses so a stuck or doubled pulse shows up.
  always @(posedge pclk) if (fault_ack === 1'b1) n_ack++;

  task automatic chk(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    u_dcw_plc.xfer(1'b0, a, 32'h0, q, e);
    chk("read data", q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    u_dcw_plc.xfer(1'b1, a, d, q, e);
    chk("pslverr", {31'h0, e}, {31'h0, x});
  endtask
  // Outputs settle one edge after the write edge; two more give margin.
  task automatic cw(input logic [15:0] w, input logic live);
    u_dcw_plc.send_word(w, live);
    repeat (3) @(posedge pclk);
  endtask
  task automatic results;
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short far beyond the fewer than 200 cycles the run needs.
  initial begin
    #100000;
    n_fail++;
    results();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("levels", {21'h0, lv}, 32'h0);
    rd(dcw_pkg::ADDR_STAT, 32'h8);
    rd(dcw_pkg::ADDR_TSEL, 32'h0001_0001);
    rd(8'h10, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    cw(16'h0400, 1'b1);
    cw(16'h047f, 1'b1);
    chk("pulse", {31'h0, pulse_enable}, 32'h1);
    chk("valid", {31'h0, data_valid}, 32'h1);
    chk("levels", {21'h0, lv}, 32'h010);
    for (int i = 0; i < 7; i++) begin
      cw(tw[i], 1'b1);
      chk("levels", {21'h0, lv}, {21'h0, tl[i]});
    end
    n_ack = 0;
    cw(16'hffff, 1'b0);
    chk("levels", {21'h0, lv}, 32'h010);
    chk("valid", {31'h0, data_valid}, 32'h0);
    chk("acks", n_ack, 32'h0);
    drive_fault <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(dcw_pkg::ADDR_STAT, 32'h0b);
    drive_fault <= 1'b0;
    n_ack = 0;
    cw(16'h04ff, 1'b1);
    chk("acks", n_ack, 32'h1);
    rd(dcw_pkg::ADDR_STAT, 32'h800c);
    wr(dcw_pkg::ADDR_TSEL, 32'h0014_03e7, 1'b0);
    rd(dcw_pkg::ADDR_TSEL, 32'h0014_03e7);
    rd(dcw_pkg::ADDR_STAT, 32'he0a4);
    wr(dcw_pkg::ADDR_CFG, 32'h0330, 1'b1);
    wr(dcw_pkg::ADDR_CFG, 32'h0230, 1'b0);
    rd(dcw_pkg::ADDR_CFG, 32'h0230);
    cw(16'hec7f, 1'b1);
    chk("levels", {21'h0, lv}, 32'h01e);
    wr(dcw_pkg::ADDR_TSEL, 32'h03e7_03e7, 1'b0);
    wr(dcw_pkg::ADDR_CFG, 32'h0831, 1'b0);
    rd(dcw_pkg::ADDR_STAT, 32'hbf3c);
    wr(dcw_pkg::ADDR_CFG, 32'h0931, 1'b1);
    wr(dcw_pkg::ADDR_TSEL, 32'h0007_0005, 1'b0);
    rd(dcw_pkg::ADDR_TSEL, 32'h0005_0005);
    wr(dcw_pkg::ADDR_CFG, 32'h0841, 1'b1);
    results();
  end
endmodule // drive_control_word_decoder_test
`default_nettype wire
